/* verilog/fecs_cmd.v */
`include "fecs_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module fecs_cmd #(
  parameter [31:0] BLK_ERASE_CYC = `FECS_BE_CYC,
  parameter [31:0] ARRAY_ERASE_CYC = `FECS_CE_CYC,
  parameter [31:0] SECTOR_ERASE_CYC = `FECS_SE_CYC,
  parameter [31:0] PROG_CYC = `FECS_PP_CYC,
  parameter [7:0] MAKER_ID = 8'h5A,
  parameter [7:0] DEVICE_ID = 8'h3C,
  parameter [7:0] MEM_TYPE = 8'h41,
  parameter [7:0] CAPACITY = 8'h18
) (
  // System clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Serial link pins; sclk, cs_b and io_in come from outside the clock domain, the outputs are registered on ref_clk.
  input wire sclk,
  input wire cs_b,
  input wire [3:0] io_in,
  output reg [3:0] io_out_r,
  output reg [3:0] io_oe_b_r,
  // Protection setting.
  input wire [4:0] protect_field,
  // Status.
  output reg busy_flag_r,
  output reg write_latch_flag_r,
  output reg [1:0] paused_flags_r,
  output reg low_power_r,
  output reg standby_r
);

  localparam [4:0] ST_OPC = 5'b00001;
  localparam [4:0] ST_ADDR = 5'b00010;
  localparam [4:0] ST_DUMMY = 5'b00100;
  localparam [4:0] ST_OUT = 5'b01000;
  localparam [4:0] ST_SKIP = 5'b10000;
  localparam [31:0] DP_CYC = `FECS_DP_CYC;
  localparam [31:0] WAKE_CYC = `FECS_WAKE_CYC;
  localparam [31:0] WAKE_ID_CYC = `FECS_WAKE_ID_CYC;
  localparam [31:0] SUS_CYC = `FECS_SUS_CYC;

  // Shift new lane bits into the low end of the receive register.
  function [31:0] shin;
    input [31:0] sh;
    input [3:0] d;
    input [2:0] lanes;
    begin
      case (lanes)
        3'd1: shin = {sh[30:0], d[0]};
        3'd2: shin = {sh[29:0], d[1:0]};
        default: shin = {sh[27:0], d};
      endcase
    end
  endfunction

  // A block is protected from the top (or bottom) by a power-of-two count.
  function prot_hit;
    input [4:0] bp;
    input [7:0] blk;
    reg [8:0] n;
    begin
      n = (bp[2:0] == 3'h7) ? 9'h100 : ((9'h001 << bp[2:0]) >> 1);
      if (bp[3])
        prot_hit = ({1'b0, blk} < n);
      else
        prot_hit = (({1'b0, blk} + n) >= 9'h100);
    end
  endfunction

  // Two-flop synchronisers for the link pins; stage three only feeds edge detection.
  reg [5:0] sync1_r;
  reg [5:0] sync2_r;
  reg sclk_d_r;
  reg cs_b_d_r;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      // Reset levels match the idle pins, clock low and select high, so no false edge follows.
      sync1_r <= 6'h10;
      sync2_r <= 6'h10;
      sclk_d_r <= 1'b0;
      cs_b_d_r <= 1'b1;
    end else begin
      sync1_r <= {sclk, cs_b, io_in};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[5];
      cs_b_d_r <= sync2_r[4];
    end
  end

  wire cs_low = ~sync2_r[4];
  wire cs_rise = sync2_r[4] & ~cs_b_d_r;
  wire sclk_rise = sync2_r[5] & ~sclk_d_r;
  wire sclk_fall = ~sync2_r[5] & sclk_d_r;
  wire [3:0] din = sync2_r[3:0];

  // Link state.
  reg [4:0] st_r;
  reg [7:0] bits_r;
  reg [4:0] cnt_r;
  reg [31:0] sh_r;
  reg [7:0] opcode_r;
  reg [23:0] addr_r;
  reg [2:0] lanes_r;
  reg id_load_r;
  reg [23:0] id_pat_r;
  reg [4:0] id_len_r;
  wire [3:0] id_bits;
  wire [7:0] op_nb = {sh_r[6:0], din[0]};
  wire [31:0] sh_nxt = shin(sh_r, din, lanes_r);
  wire [4:0] cnt_nxt = cnt_r + {2'b00, lanes_r};
  wire id_step = sclk_fall & cs_low & (st_r == ST_OUT);

  // Engine state used by decode.
  reg dp_pend_r;
  reg wake_pend_r;
  reg sus_wait_r;
  reg op_prog_r;
  reg op_pausable_r;
  reg [31:0] op_cnt_r;
  reg [31:0] pm_cnt_r;
  reg [31:0] sus_cnt_r;

  fecs_id_shift #(.W(24)) u_id (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(id_load_r),
    .pattern(id_pat_r),
    .len(id_len_r),
    .lanes(lanes_r),
    .step(id_step),
    .bits(id_bits)
  );

  // Frame receiver; state, counts and lane width restart whenever select is high, while opcode and address are held.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r <= ST_OPC;
      bits_r <= 8'd0;
      cnt_r <= 5'd0;
      sh_r <= 32'h0;
      opcode_r <= 8'h00;
      addr_r <= 24'h0;
      lanes_r <= 3'd1;
      id_load_r <= 1'b0;
      id_pat_r <= 24'h0;
      id_len_r <= 5'd8;
      io_out_r <= 4'h0;
      io_oe_b_r <= 4'hF;
    end else if (!cs_low) begin
      st_r <= ST_OPC;
      bits_r <= 8'd0;
      cnt_r <= 5'd0;
      lanes_r <= 3'd1;
      id_load_r <= 1'b0;
      io_oe_b_r <= 4'hF;
    end else begin
      id_load_r <= 1'b0;
      if (sclk_rise) begin
        if (bits_r != `FECS_BITS_SAT)
          bits_r <= bits_r + ((st_r == ST_OPC) ? 8'd1 : {5'd0, lanes_r});
        case (st_r)
          ST_OPC: begin
            sh_r <= shin(sh_r, din, 3'd1);
            if (bits_r == `FECS_OPC_BITS - 8'd1) begin
              opcode_r <= op_nb;
              cnt_r <= 5'd0;
              st_r <= ST_SKIP;
              if (!low_power_r || op_nb == `FECS_OP_WAKE_ID) begin
                case (op_nb)
                  `FECS_OP_WAKE_ID: if (!busy_flag_r) st_r <= ST_DUMMY;
                  `FECS_OP_IDENT: begin
                    if (!busy_flag_r) begin
                      st_r <= ST_OUT;
                      id_load_r <= 1'b1;
                      id_pat_r <= {MAKER_ID, MEM_TYPE, CAPACITY};
                      id_len_r <= 5'd24;
                    end
                  end
                  `FECS_OP_MAKER_ID: if (!busy_flag_r) st_r <= ST_ADDR;
                  `FECS_OP_MAKER_ID_DUAL: begin
                    if (!busy_flag_r) begin
                      st_r <= ST_ADDR;
                      lanes_r <= 3'd2;
                    end
                  end
                  `FECS_OP_MAKER_ID_QUAD: begin
                    if (!busy_flag_r) begin
                      st_r <= ST_ADDR;
                      lanes_r <= 3'd4;
                    end
                  end
                  `FECS_OP_BLOCK64, `FECS_OP_SECTOR, `FECS_OP_BLOCK32, `FECS_OP_PROG,
                  `FECS_OP_PROG_QUAD: st_r <= ST_ADDR;
                  default: st_r <= ST_SKIP;
                endcase
              end
            end
          end
          ST_ADDR: begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            if (cnt_nxt == `FECS_ADDR_BITS) begin
              addr_r <= sh_nxt[23:0];
              st_r <= ST_SKIP;
              if (opcode_r == `FECS_OP_MAKER_ID || opcode_r == `FECS_OP_MAKER_ID_DUAL ||
                  opcode_r == `FECS_OP_MAKER_ID_QUAD) begin
                st_r <= ST_OUT;
                id_load_r <= 1'b1;
                id_len_r <= 5'd16;
                if (sh_nxt[23:0] == `FECS_DEV_FIRST_ADDR)
                  id_pat_r <= {8'h00, DEVICE_ID, MAKER_ID};
                else
                  id_pat_r <= {8'h00, MAKER_ID, DEVICE_ID};
              end
            end
          end
          ST_DUMMY: begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == `FECS_ADDR_BITS) begin
              st_r <= ST_OUT;
              id_load_r <= 1'b1;
              id_pat_r <= {16'h0000, DEVICE_ID};
              id_len_r <= 5'd8;
            end
          end
          ST_OUT: st_r <= ST_OUT;
          ST_SKIP: st_r <= ST_SKIP;
          default: st_r <= ST_SKIP;
        endcase
      end
      // Output bits change on the falling link clock so the host samples them stable.
      if (id_step) begin
        case (lanes_r)
          3'd1: begin
            io_out_r <= {2'b00, id_bits[0], 1'b0};
            io_oe_b_r <= 4'b1101;
          end
          3'd2: begin
            io_out_r <= {2'b00, id_bits[1:0]};
            io_oe_b_r <= 4'b1100;
          end
          default: begin
            io_out_r <= id_bits;
            io_oe_b_r <= 4'b0000;
          end
        endcase
      end
    end
  end

  // Command execution happens only on select rising, with the exact bit count for all but program and wake.
  reg ex_write_latch_set_cmd, ex_array, ex_block, ex_sector, ex_prog, ex_dp, ex_sus, ex_res, ex_wake;
  always @* begin
    ex_write_latch_set_cmd = 1'b0;
    ex_array = 1'b0;
    ex_block = 1'b0;
    ex_sector = 1'b0;
    ex_prog = 1'b0;
    ex_dp = 1'b0;
    ex_sus = 1'b0;
    ex_res = 1'b0;
    ex_wake = 1'b0;
    if (cs_rise && low_power_r) begin
      ex_wake = !wake_pend_r && opcode_r == `FECS_OP_WAKE_ID && bits_r >= `FECS_OPC_BITS;
    end else if (cs_rise && !dp_pend_r && !busy_flag_r) begin
      ex_write_latch_set_cmd = (opcode_r == `FECS_OP_WRITE_LATCH_SET_CMD) && (bits_r == `FECS_OPC_BITS);
      ex_array = (opcode_r == `FECS_OP_ARRAY_A || opcode_r == `FECS_OP_ARRAY_B) &&
                 (bits_r == `FECS_OPC_BITS) && write_latch_flag_r &&
                 (protect_field == 5'h00) && (paused_flags_r == 2'b00);
      ex_block = (opcode_r == `FECS_OP_BLOCK64) && (bits_r == `FECS_ADDR_CMD_BITS) &&
                 write_latch_flag_r && !prot_hit(protect_field, addr_r[23:16]) &&
                 (paused_flags_r == 2'b00);
      ex_sector = (opcode_r == `FECS_OP_SECTOR || opcode_r == `FECS_OP_BLOCK32) &&
                  (bits_r == `FECS_ADDR_CMD_BITS) && write_latch_flag_r &&
                  !prot_hit(protect_field, addr_r[23:16]) && (paused_flags_r == 2'b00);
      ex_prog = (opcode_r == `FECS_OP_PROG || opcode_r == `FECS_OP_PROG_QUAD) &&
                (bits_r >= `FECS_PROG_MIN_BITS) && (bits_r[2:0] == 3'd0) &&
                write_latch_flag_r && !prot_hit(protect_field, addr_r[23:16]) &&
                (paused_flags_r == 2'b00);
      ex_dp = (opcode_r == `FECS_OP_LOW_POWER) && (bits_r == `FECS_OPC_BITS);
      ex_res = (opcode_r == `FECS_OP_CONTINUE) && (bits_r == `FECS_OPC_BITS) &&
               (paused_flags_r != 2'b00);
    end else if (cs_rise && busy_flag_r && !sus_wait_r) begin
      ex_sus = (opcode_r == `FECS_OP_PAUSE) && (bits_r == `FECS_OPC_BITS) &&
               (paused_flags_r == 2'b00) && op_pausable_r;
    end
  end

  wire op_start = ex_array | ex_block | ex_sector | ex_prog;

  // Self-timed cycle, pause, and low-power engine.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      busy_flag_r <= 1'b0;
      write_latch_flag_r <= 1'b0;
      paused_flags_r <= 2'b00;
      low_power_r <= 1'b0;
      standby_r <= 1'b1;
      dp_pend_r <= 1'b0;
      wake_pend_r <= 1'b0;
      sus_wait_r <= 1'b0;
      op_prog_r <= 1'b0;
      op_pausable_r <= 1'b0;
      op_cnt_r <= 32'd0;
      pm_cnt_r <= 32'd0;
      sus_cnt_r <= 32'd0;
    end else begin
      standby_r <= !cs_low && !busy_flag_r && !low_power_r && !dp_pend_r;
      if (ex_write_latch_set_cmd)
        write_latch_flag_r <= 1'b1;
      else if (op_start)
        write_latch_flag_r <= 1'b0;
      if (op_start) begin
        busy_flag_r <= 1'b1;
        op_prog_r <= ex_prog;
        op_pausable_r <= !ex_array;
        if (ex_array)
          op_cnt_r <= ARRAY_ERASE_CYC;
        else if (ex_block)
          op_cnt_r <= BLK_ERASE_CYC;
        else if (ex_sector)
          op_cnt_r <= SECTOR_ERASE_CYC;
        else
          op_cnt_r <= PROG_CYC;
      end else if (ex_sus) begin
        paused_flags_r <= op_prog_r ? 2'b10 : 2'b01;
        sus_wait_r <= 1'b1;
        sus_cnt_r <= SUS_CYC;
      end else if (ex_res) begin
        paused_flags_r <= 2'b00;
        busy_flag_r <= 1'b1;
      end else if (busy_flag_r && sus_wait_r) begin
        // The remaining cycle count is frozen until the operation continues.
        sus_cnt_r <= sus_cnt_r - 32'd1;
        if (sus_cnt_r <= 32'd1) begin
          busy_flag_r <= 1'b0;
          sus_wait_r <= 1'b0;
        end
      end else if (busy_flag_r) begin
        op_cnt_r <= op_cnt_r - 32'd1;
        if (op_cnt_r <= 32'd1)
          busy_flag_r <= 1'b0;
      end
      // One counter serves both the entry and the wake delay; they never overlap.
      if (ex_dp) begin
        dp_pend_r <= 1'b1;
        pm_cnt_r <= DP_CYC;
      end else if (ex_wake) begin
        wake_pend_r <= 1'b1;
        pm_cnt_r <= (bits_r == `FECS_OPC_BITS) ? WAKE_CYC : WAKE_ID_CYC;
      end else if (dp_pend_r || wake_pend_r) begin
        pm_cnt_r <= pm_cnt_r - 32'd1;
        if (pm_cnt_r <= 32'd1) begin
          dp_pend_r <= 1'b0;
          wake_pend_r <= 1'b0;
          low_power_r <= dp_pend_r;
        end
      end
    end
  end

endmodule // fecs_cmd
`default_nettype wire

/* verilog/fecs_defines.vh */
`ifndef FECS_DEFINES_VH
`define FECS_DEFINES_VH

// System clock (ref_clk) rate of the block, in MHz.
`define FECS_CLK_MHZ 125

// Opcodes decoded by the command interpreter.
`define FECS_OP_WRITE_LATCH_SET_CMD 8'h06
`define FECS_OP_ARRAY_A 8'h60
`define FECS_OP_ARRAY_B 8'hC7
`define FECS_OP_BLOCK64 8'hD8
`define FECS_OP_SECTOR 8'h20
`define FECS_OP_BLOCK32 8'h52
`define FECS_OP_PROG 8'h02
`define FECS_OP_PROG_QUAD 8'h32
`define FECS_OP_LOW_POWER 8'hB9
`define FECS_OP_WAKE_ID 8'hAB
`define FECS_OP_MAKER_ID 8'h90
`define FECS_OP_MAKER_ID_DUAL 8'h92
`define FECS_OP_MAKER_ID_QUAD 8'h94
`define FECS_OP_IDENT 8'h9F
`define FECS_OP_PAUSE 8'h75
`define FECS_OP_CONTINUE 8'h7A

// Frame lengths, in link bits.
`define FECS_OPC_BITS 8'd8
`define FECS_ADDR_BITS 5'd24
`define FECS_ADDR_CMD_BITS 8'd32
`define FECS_PROG_MIN_BITS 8'd40
`define FECS_BITS_SAT 8'hF8

// Address of the maker/device read that puts the device ID first.
`define FECS_DEV_FIRST_ADDR 24'h000001

// Short delays in ns, and their counts in clock cycles (rounded up, the pause count rounded down).
`define FECS_DP_NS 3000
`define FECS_WAKE_NS 3000
`define FECS_WAKE_ID_NS 1800
`define FECS_SUS_NS 2000
`define FECS_DP_CYC ((`FECS_DP_NS * `FECS_CLK_MHZ + 999) / 1000)
`define FECS_WAKE_CYC ((`FECS_WAKE_NS * `FECS_CLK_MHZ + 999) / 1000)
`define FECS_WAKE_ID_CYC ((`FECS_WAKE_ID_NS * `FECS_CLK_MHZ + 999) / 1000)
`define FECS_SUS_CYC ((`FECS_SUS_NS * `FECS_CLK_MHZ) / 1000)

// Self-timed cycle lengths in us, and their counts in clock cycles.
`define FECS_BE_US 150000
`define FECS_CE_US 9000000
`define FECS_SE_US 50000
`define FECS_PP_US 600
`define FECS_BE_CYC (`FECS_BE_US * `FECS_CLK_MHZ)
`define FECS_CE_CYC (`FECS_CE_US * `FECS_CLK_MHZ)
`define FECS_SE_CYC (`FECS_SE_US * `FECS_CLK_MHZ)
`define FECS_PP_CYC (`FECS_PP_US * `FECS_CLK_MHZ)

`endif

/* verilog/fecs_id_shift.v */
`timescale 1ns/1ps
`default_nettype none
// Rotating shifter that presents identification bits one, two or four at a time.
module fecs_id_shift #(
  parameter W = 24
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Pattern load.
  input wire load,
  input wire [W-1:0] pattern,
  input wire [4:0] len,
  // Stepping.
  input wire [2:0] lanes,
  input wire step,
  // Current output bits, most significant first in the highest lane.
  output wire [3:0] bits
);

  reg [W-1:0] data_r;
  reg [4:0] len_r;
  reg [4:0] idx_r;
  wire [4:0] sa;
  wire [W-1:0] shr;
  wire [4:0] idx_nxt;

  // The window starts at the top of the pattern and wraps so the ID repeats.
  assign sa = len_r - idx_r - {2'b00, lanes};
  assign shr = data_r >> sa;
  assign bits = shr[3:0];
  assign idx_nxt = idx_r + {2'b00, lanes};

  // Load wins over step, so a fresh frame always begins at the top.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      data_r <= {W{1'b0}};
      len_r <= 5'd8;
      idx_r <= 5'd0;
    end else if (load) begin
      data_r <= pattern;
      len_r <= len;
      idx_r <= 5'd0;
    end else if (step) begin
      idx_r <= (idx_nxt >= len_r) ? 5'd0 : idx_nxt;
    end
  end

endmodule // fecs_id_shift
`default_nettype wire

/* dv/fecs_cmd_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the pins and status flags of the command interpreter.
module fecs_cmd_checker (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Link pins.
  input wire sclk,
  input wire cs_b,
  input wire [3:0] io_in,
  input wire [3:0] io_out_r,
  input wire [3:0] io_oe_b_r,
  // Protection and status.
  input wire [4:0] protect_field,
  input wire busy_flag_r,
  input wire write_latch_flag_r,
  input wire [1:0] paused_flags_r,
  input wire low_power_r,
  input wire standby_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Cycles since select was last low; it saturates so that a long idle never wraps.
  reg [9:0] hi_cnt_r;
  always @(posedge ref_clk) begin
    if (!rst_b || !cs_b) hi_cnt_r <= 10'h000;
    else if (hi_cnt_r != 10'h3FF) hi_cnt_r <= hi_cnt_r + 10'h001;
  end
  a_reset_standby: assert property (
    $rose(rst_b) |-> standby_r && !busy_flag_r && !low_power_r) else $error("bad reset state");
  a_busy_after_cs: assert property (
    $rose(busy_flag_r) |-> cs_b && $past(cs_b, 2) && paused_flags_r == 2'b00)
    else $error("busy rose without a finished frame");
  a_pause_needs_busy: assert property (
    $rose(|paused_flags_r) |-> $past(busy_flag_r)) else $error("pause taken while idle");
  a_pause_latency: assert property (
    $rose(|paused_flags_r) |-> ##[0:260] !busy_flag_r) else $error("pause too slow");
  a_lp_no_busy: assert property (
    low_power_r |-> !busy_flag_r && !standby_r) else $error("low power while busy");
  a_lp_entry: assert property (
    $rose(low_power_r) |-> hi_cnt_r >= 10'd365 && hi_cnt_r <= 10'd395)
    else $error("low power entry delay wrong");
  a_lp_exit: assert property (
    $fell(low_power_r) |-> (hi_cnt_r >= 10'd215 && hi_cnt_r <= 10'd240)
      || (hi_cnt_r >= 10'd365 && hi_cnt_r <= 10'd395)) else $error("wake timing wrong");
  a_out_on_fall: assert property (
    !$stable(io_out_r) |-> !sclk) else $error("output moved while clock high");
  a_oe_release: assert property (
    cs_b [*8] |-> io_oe_b_r == 4'hF) else $error("driving while deselected");
  a_busy_quiet: assert property (
    busy_flag_r && $past(busy_flag_r, 4) |-> io_oe_b_r == 4'hF) else $error("ID out while busy");
  a_resume_busy: assert property (
    $fell(|paused_flags_r) |-> busy_flag_r) else $error("continue did not raise busy");
endmodule // fecs_cmd_checker
bind fecs_cmd fecs_cmd_checker i_fecs_cmd_checker (.ref_clk(ref_clk), .rst_b(rst_b),
  .sclk(sclk), .cs_b(cs_b), .io_in(io_in), .io_out_r(io_out_r), .io_oe_b_r(io_oe_b_r),
  .protect_field(protect_field), .busy_flag_r(busy_flag_r),
  .write_latch_flag_r(write_latch_flag_r), .paused_flags_r(paused_flags_r),
  .low_power_r(low_power_r), .standby_r(standby_r));
`default_nettype wire

/* dv/fecs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the link: clock, select and data out, answer bits captured at each rise.
module fecs_host_model (
  // Link pins seen by the device.
  output logic sclk,
  output logic cs_b,
  output logic [3:0] io_in,
  // Device drive and enables.
  input wire logic [3:0] io_out_r,
  input wire logic [3:0] io_oe_b_r
);
  logic [3:0] drv = 4'h0;
  logic [3:0] junk = 4'h5;
  logic drv_en = 1'b0;
  logic [31:0] rx_data = 32'h0;
  event got;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
  end
  // Undriven lines float, so they wander rather than hold a stale level.
  always #8 junk = ~junk;
  assign io_in = (~io_oe_b_r & io_out_r) | (io_oe_b_r & (drv_en ? drv : junk));
  // One framed transfer; opcode on one line, later bits on txl lines, answer on rxl lines.
  task automatic frame(input logic [63:0] tx, input int nrise, input int txl,
                       input int nrx, input int rxl);
    int p;
    int ln;
    p = 63;
    rx_data = 32'h0;
    cs_b = 1'b0;
    for (int i = 0; i < nrise + nrx; i++) begin
      ln = (i < 8) ? 1 : txl;
      drv_en = (i < nrise);
      for (int k = ln - 1; k >= 0 && i < nrise; k--) begin
        drv[k] = tx[p];
        p--;
      end
      #62.5 sclk = 1'b1;
      for (int k = rxl - 1; k >= 0 && i >= nrise; k--) begin
        rx_data = {rx_data[30:0], (rxl == 1) ? io_out_r[1] : io_out_r[k]};
      end
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_b = 1'b1;
    drv_en = 1'b0;
    if (nrx > 0) ->got;
  endtask
endmodule // fecs_host_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench; the host model drives the link and a monitor checks ID answers.
module tb_top;
  localparam int CYC = 4000;
  // ID values are arbitrary.
  localparam logic [7:0] MK = 8'h5A, DV = 8'h3C, TY = 8'h41, CP = 8'h18;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] pf = 5'h00;
  wire sclk, cs_b, busy, write_latch_flag, lp, sby;
  wire [3:0] io_in, io_out, oe_b;
  wire [1:0] paused;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] exp_q[$];
  logic [63:0] id_tx [6] = '{{8'h9F, 56'h0}, {8'hAB, 56'h0}, {8'h90, 56'h0},
    {8'h90, 24'h1, 32'h0}, {8'h92, 56'h0}, {8'h94, 24'h1, 32'h0}};
  int id_n [6] = '{8, 32, 32, 32, 20, 14};
  int id_l [6] = '{1, 1, 1, 1, 2, 4};
  int id_rn [6] = '{32, 16, 16, 16, 8, 4};
  logic [31:0] id_exp [6] = '{{MK, TY, CP, MK}, {16'h0, DV, DV}, {16'h0, MK, DV},
    {16'h0, DV, MK}, {16'h0, MK, DV}, {16'h0, DV, MK}};
  fecs_cmd #(.BLK_ERASE_CYC(CYC), .ARRAY_ERASE_CYC(CYC), .SECTOR_ERASE_CYC(CYC),
    .PROG_CYC(CYC), .MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(TY), .CAPACITY(CP)) i_fecs_cmd (
    .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .io_in(io_in),
    .io_out_r(io_out), .io_oe_b_r(oe_b), .protect_field(pf), .busy_flag_r(busy),
    .write_latch_flag_r(write_latch_flag), .paused_flags_r(paused), .low_power_r(lp), .standby_r(sby));
  fecs_host_model i_fecs_host_model (.sclk(sclk), .cs_b(cs_b), .io_in(io_in),
    .io_out_r(io_out), .io_oe_b_r(oe_b));
  always #4 ref_clk = ~ref_clk;
  // A hang is cut short well past the expected run of about 47000 cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Each captured answer is matched against the oldest note left by the driver.
  always @(i_fecs_host_model.got) begin
    if (exp_q.size() == 0) check("id_unasked", 32'h1, 32'h0);
    else check("id_data", i_fecs_host_model.rx_data, exp_q.pop_front());
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Frames start just after an edge; flags settle within 8 cycles of select rising.
  task automatic fr(input logic [63:0] tx, input int n, input int txl, input int nrx, input int rxl);
    @(posedge ref_clk);
    #1;
    i_fecs_host_model.frame(tx, n, txl, nrx, rxl);
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic op(input logic [7:0] code);
    fr({code, 56'h0}, 8, 1, 0, 1);
  endtask
  task automatic erase(input logic [23:0] a);
    op(8'h06);
    fr({8'hD8, a, 32'h0}, 32, 1, 0, 1);
  endtask
  // Flag order: busy, latch, paused[1:0], low power, standby.
  task automatic flags(input logic [5:0] e);
    check("flags", {26'h0, busy, write_latch_flag, paused, lp, sby}, {26'h0, e});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < CYC + 100) begin
      @(posedge ref_clk);
      n++;
    end
    check("busy_end", {31'h0, busy}, 32'h0);
  endtask
  task automatic rnd_erase();
    erase({8'($urandom_range(254)), 16'($urandom)});
  endtask
  initial begin
    cyc = $urandom(65);
    cyc = 0;
    repeat (20) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge ref_clk);
    flags(6'b000001);
    check("oe_idle", {28'h0, oe_b}, 32'hF);
    #1 pf = 5'h01;
    erase({8'hFF, 16'($urandom)});
    flags(6'b010001);
    rnd_erase();
    flags(6'b100000);
    wait_idle();
    op(8'h06);
    op(8'hC7);
    flags(6'b010001);
    $display("test protect done");
    #1 pf = 5'h00;
    for (int i = 0; i < 2; i++) begin
      op(8'h06);
      fr({i ? 8'hC7 : 8'h60, 56'h0}, 9, 1, 0, 1);
      flags(6'b010001);
      fr({i ? 8'hC7 : 8'h60, 56'h0}, 7, 1, 0, 1);
      flags(6'b010001);
      op(i ? 8'hC7 : 8'h60);
      flags(6'b100000);
      wait_idle();
    end
    $display("test array erase done");
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back(id_exp[i]);
      fr(id_tx[i], id_n[i], id_l[i], id_rn[i], id_l[i]);
    end
    $display("test id reads done");
    rnd_erase();
    op(8'hAB);
    fr({8'h9F, 56'h0}, 8, 1, 0, 1);
    op(8'hB9);
    repeat (400) @(posedge ref_clk);
    flags(6'b100000);
    wait_idle();
    op(8'hB9);
    repeat (360) @(posedge ref_clk);
    flags(6'b000000);
    repeat (20) @(posedge ref_clk);
    flags(6'b000010);
    rnd_erase();
    flags(6'b000010);
    op(8'hAB);
    repeat (380) @(posedge ref_clk);
    flags(6'b000001);
    op(8'hB9);
    repeat (390) @(posedge ref_clk);
    exp_q.push_back({16'h0, DV, DV});
    fr({8'hAB, 56'h0}, 32, 1, 16, 1);
    repeat (240) @(posedge ref_clk);
    flags(6'b000001);
    $display("test low power done");
    rnd_erase();
    op(8'h75);
    flags(6'b100100);
    repeat (260) @(posedge ref_clk);
    flags(6'b000101);
    op(8'h75);
    flags(6'b000101);
    rnd_erase();
    flags(6'b010101);
    op(8'h7A);
    flags(6'b110000);
    wait_idle();
    op(8'h75);
    flags(6'b010001);
    fr({8'h02, 56'h0}, 40, 1, 0, 1);
    op(8'h75);
    flags(6'b101000);
    repeat (260) @(posedge ref_clk);
    op(8'h7A);
    flags(6'b100000);
    wait_idle();
    // Sector and 32KB erase also run as timed busy cycles.
    for (int i = 0; i < 2; i++) begin
      op(8'h06);
      fr({i ? 8'h52 : 8'h20, 56'h0}, 32, 1, 0, 1);
      flags(6'b100000);
      wait_idle();
    end
    $display("test pause done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
